// *** include/afc_pkg.sv ***
/*
  package for the filter setup 0 configuration block: register map,
  field positions, reset values, decode encodings and postfilter figures.
  assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
// Operation
// - the setup 0 filter config register is 16 bits, reset value 0x0500.
// - any write to it aborts the conversion, restarts at the first channel.
// - bit 15 set makes bits 14..0 the sinc3 decimation rate, options ignored.
// - direct map, one channel: rate is modulator rate over 32 times bits 14..0.
// - bits 14..12 and 7 are reserved, read-only, reset to zero.
// - bit 11 enables the 50/60 Hz rejection postfilter; resets to 0.
// - the postfilter works only while the filter order field is 00.
// - bits 10..8 pick the postfilter variant; reset value 0x5.
// - postfilter code 010 is 27 SPS, 36.7 ms; 011 is 21.25 SPS, 40 ms.
// - postfilter code 101 is 20 SPS, 50 ms; 110 is 16.67 SPS, 60 ms.
// - bits 6..5 pick the filter order for this setup; reset to zero.
// - order 00 selects sinc5 plus sinc1 (default); order 11 selects sinc3.
// - bits 4..0 select the output data rate for this setup.
`default_nettype none

package afc_pkg;
  localparam logic [7:0]  CFG_OFFSET   = 8'h28;
  localparam logic [7:0]  STAT_OFFSET  = 8'h2c;
  localparam logic [15:0] CFG_RESET    = 16'h0500;
  localparam logic [15:0] CFG_WMASK    = 16'h8f7f;
  localparam logic [15:0] CFG_DIR_MASK = 16'hffff;

  localparam int DIRECT_BIT  = 15;
  localparam int DECIM_HI    = 14;
  localparam int PF_EN_BIT   = 11;
  localparam int PF_SEL_HI   = 10;
  localparam int PF_SEL_LO   = 8;
  localparam int ORDER_HI    = 6;
  localparam int ORDER_LO    = 5;
  localparam int RATE_HI     = 4;
  localparam int DIRECT_SCALE = 32;

  localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
  localparam logic [1:0] ORDER_SINC3       = 2'h3;

  localparam logic [2:0] PF_27SPS  = 3'h2;
  localparam logic [2:0] PF_21SPS  = 3'h3;
  localparam logic [2:0] PF_20SPS  = 3'h5;
  localparam logic [2:0] PF_16SPS  = 3'h6;

  // settling in tenths of a millisecond, rate in hundredths of a sample/s
  localparam logic [15:0] SETTLE_27  = 16'h016f;
  localparam logic [15:0] SETTLE_21  = 16'h0190;
  localparam logic [15:0] SETTLE_20  = 16'h01f4;
  localparam logic [15:0] SETTLE_16  = 16'h0258;
  localparam logic [15:0] RATE_27    = 16'h0a8c;
  localparam logic [15:0] RATE_21    = 16'h084d;
  localparam logic [15:0] RATE_20    = 16'h07d0;
  localparam logic [15:0] RATE_16    = 16'h0683;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_SINC5_SINC1 = 2'b00,
    MODE_UNDEF       = 2'b01,
    MODE_DIRECT      = 2'b10,
    MODE_SINC3       = 2'b11
  } afc_mode_e;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } afc_seq_e;
endpackage

`default_nettype wire

// *** hw/afc_conv_timer.sv ***
/*
  conversion timer: counts modulator ticks and pulses once per period.
  assumes tick_in is a one-cycle enable at the modulator rate.
*/
`default_nettype none

module afc_conv_timer #(
  parameter int CNT_W = 24
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             restart_in,
  input  wire logic             run_in,
  input  wire logic             tick_in,
  input  wire logic [CNT_W-1:0] period_in,
  output logic                  done_out
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_done;

  if (CNT_W < 20) begin : g_chk
    $error("afc_conv_timer: CNT_W too small for 32 x 15-bit decimation");
  end

  // a zero period never completes: conversions stall rather than run wild
  always_comb begin
    next_count = count;
    next_done  = 1'b0;
    if (restart_in || !run_in) begin
      next_count = '0;
    end else if (tick_in && period_in != '0) begin
      if (count + CNT_W'(1) >= period_in) begin
        next_count = '0;
        next_done  = 1'b1;
      end else begin
        next_count = count + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count    <= '0;
      done_out <= 1'b0;
    end else begin
      count    <= next_count;
      done_out <= next_done;
    end
  end
endmodule

`default_nettype wire

// *** hw/afc_filter_setup.sv ***
/*
  filter setup 0 configuration: AXI4-Lite register slave, filter decode,
  and the channel conversion sequencer that a config write restarts.
  assumes MOD_TICK_IN pulses at the modulator rate and CONV_PERIOD_IN
  gives modulator ticks per result outside direct decimation mode.
*/
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none

module afc_filter_setup #(
  parameter int NUM_CH = 4,
  parameter int CNT_W  = 24
) (
  input  wire logic              MCLK_IN,
  input  wire logic              RST_B_IN,
  input  wire logic [7:0]        S_AXI_AWADDR_IN,
  input  wire logic              S_AXI_AWVALID_IN,
  output logic                   S_AXI_AWREADY_OUT,
  input  wire logic [31:0]       S_AXI_WDATA_IN,
  input  wire logic [3:0]        S_AXI_WSTRB_IN,
  input  wire logic              S_AXI_WVALID_IN,
  output logic                   S_AXI_WREADY_OUT,
  output logic [1:0]             S_AXI_BRESP_OUT,
  output logic                   S_AXI_BVALID_OUT,
  input  wire logic              S_AXI_BREADY_IN,
  input  wire logic [7:0]        S_AXI_ARADDR_IN,
  input  wire logic              S_AXI_ARVALID_IN,
  output logic                   S_AXI_ARREADY_OUT,
  output logic [31:0]            S_AXI_RDATA_OUT,
  output logic [1:0]             S_AXI_RRESP_OUT,
  output logic                   S_AXI_RVALID_OUT,
  input  wire logic              S_AXI_RREADY_IN,
  input  wire logic [NUM_CH-1:0] CHAN_EN_IN,
  input  wire logic              MOD_TICK_IN,
  input  wire logic [CNT_W-1:0]  CONV_PERIOD_IN,
  output logic [1:0]             FILTER_MODE_OUT,
  output logic                   POSTFILT_ACTIVE_OUT,
  output logic [2:0]             POSTFILT_SEL_OUT,
  output logic [15:0]            POSTFILT_SETTLE_OUT,
  output logic [15:0]            POSTFILT_RATE_OUT,
  output logic [4:0]             RATE_SEL_OUT,
  output logic [14:0]            DECIM_OUT,
  output logic                   CONV_ABORT_OUT,
  output logic                   RESULT_VALID_OUT,
  output logic [3:0]             RESULT_CH_OUT
);
  if (NUM_CH < 1 || NUM_CH > 16) begin : g_chk
    $error("afc_filter_setup: NUM_CH must be 1 to 16");
  end

  function automatic logic [3:0] first_ch(input logic [NUM_CH-1:0] en);
    first_ch = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (en[i]) begin
        first_ch = 4'(i);
      end
    end
  endfunction

  // next enabled channel after cur, wrapping to the first enabled one
  function automatic logic [3:0] next_ch(input logic [NUM_CH-1:0] en,
                                         input logic [3:0]        cur);
    logic found;
    found   = 1'b0;
    next_ch = first_ch(en);
    for (int i = 0; i < NUM_CH; i++) begin
      if (!found && en[i] && 4'(i) > cur) begin
        next_ch = 4'(i);
        found   = 1'b1;
      end
    end
  endfunction

  function automatic logic is_cfg(input logic [7:0] a);
    is_cfg = a[7:2] == afc_pkg::CFG_OFFSET[7:2];
  endfunction

  // ---------------- register bus ----------------
  logic        aw_full, w_full, bvalid, rvalid;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] cfg;
  logic        cfg_wr;
  logic        next_aw_full, next_w_full, next_bvalid, next_rvalid;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data, next_rdata;
  logic [3:0]  next_w_strb;
  logic [1:0]  next_bresp, next_rresp;
  logic [15:0] next_cfg, merged;
  logic [15:0] status;
  logic [7:0]  restarts;

  assign S_AXI_AWREADY_OUT = !aw_full;
  assign S_AXI_WREADY_OUT  = !w_full;
  assign S_AXI_BVALID_OUT  = bvalid;
  assign S_AXI_BRESP_OUT   = bresp;
  assign S_AXI_ARREADY_OUT = !rvalid;
  assign S_AXI_RVALID_OUT  = rvalid;
  assign S_AXI_RDATA_OUT   = rdata;
  assign S_AXI_RRESP_OUT   = rresp;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_cfg     = cfg;
    cfg_wr       = 1'b0;
    merged       = cfg;
    if (S_AXI_AWVALID_IN && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = S_AXI_AWADDR_IN;
    end
    if (S_AXI_WVALID_IN && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = S_AXI_WDATA_IN;
      next_w_strb = S_AXI_WSTRB_IN;
    end
    if (bvalid && S_AXI_BREADY_IN) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !bvalid) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = afc_pkg::RESP_SLVERR;
      if (is_cfg(aw_addr)) begin
        next_bresp = afc_pkg::RESP_OKAY;
        cfg_wr     = 1'b1;
        if (w_strb[0]) begin
          merged[7:0] = w_data[7:0];
        end
        if (w_strb[1]) begin
          merged[15:8] = w_data[15:8];
        end
        // reserved bits hold zero unless they carry the decimation rate
        next_cfg = merged[afc_pkg::DIRECT_BIT]
                 ? (merged & afc_pkg::CFG_DIR_MASK)
                 : (merged & afc_pkg::CFG_WMASK);
      end
    end
    if (rvalid && S_AXI_RREADY_IN) begin
      next_rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_IN && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = afc_pkg::RESP_OKAY;
      next_rdata  = '0;
      if (is_cfg(S_AXI_ARADDR_IN)) begin
        next_rdata = {16'h0000, cfg};
      end else if (S_AXI_ARADDR_IN[7:2] == afc_pkg::STAT_OFFSET[7:2]) begin
        next_rdata = {16'h0000, status};
      end else begin
        next_rresp = afc_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      w_full  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= afc_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= afc_pkg::RESP_OKAY;
      cfg     <= afc_pkg::CFG_RESET;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      cfg     <= next_cfg;
    end
  end

  // ---------------- filter decode ----------------
  logic       direct;
  logic [1:0] order;
  logic [2:0] pf_sel;
  logic [1:0] next_mode;
  logic       next_pf_act;
  logic [15:0] next_settle, next_pf_rate;
  logic [CNT_W-1:0] period;

  assign direct = cfg[afc_pkg::DIRECT_BIT];
  assign order  = cfg[afc_pkg::ORDER_HI:afc_pkg::ORDER_LO];
  assign pf_sel = cfg[afc_pkg::PF_SEL_HI:afc_pkg::PF_SEL_LO];

  always_comb begin
    next_settle  = '0;
    next_pf_rate = '0;
    case (pf_sel)
      afc_pkg::PF_27SPS: begin
        next_settle  = afc_pkg::SETTLE_27;
        next_pf_rate = afc_pkg::RATE_27;
      end
      afc_pkg::PF_21SPS: begin
        next_settle  = afc_pkg::SETTLE_21;
        next_pf_rate = afc_pkg::RATE_21;
      end
      afc_pkg::PF_20SPS: begin
        next_settle  = afc_pkg::SETTLE_20;
        next_pf_rate = afc_pkg::RATE_20;
      end
      afc_pkg::PF_16SPS: begin
        next_settle  = afc_pkg::SETTLE_16;
        next_pf_rate = afc_pkg::RATE_16;
      end
      default: begin
        next_settle  = '0;
        next_pf_rate = '0;
      end
    endcase
    case (order)
      afc_pkg::ORDER_SINC5_SINC1: next_mode = afc_pkg::MODE_SINC5_SINC1;
      afc_pkg::ORDER_SINC3:       next_mode = afc_pkg::MODE_SINC3;
      default:                    next_mode = afc_pkg::MODE_UNDEF;
    endcase
    next_pf_act = cfg[afc_pkg::PF_EN_BIT]
                && order == afc_pkg::ORDER_SINC5_SINC1;
    if (direct) begin
      next_mode   = afc_pkg::MODE_DIRECT;
      next_pf_act = 1'b0;
    end
    period = direct
           ? CNT_W'(cfg[afc_pkg::DECIM_HI:0]) * CNT_W'(afc_pkg::DIRECT_SCALE)
           : CONV_PERIOD_IN;
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      FILTER_MODE_OUT     <= afc_pkg::MODE_SINC5_SINC1;
      POSTFILT_ACTIVE_OUT <= 1'b0;
      POSTFILT_SEL_OUT    <=
        afc_pkg::CFG_RESET[afc_pkg::PF_SEL_HI:afc_pkg::PF_SEL_LO];
      POSTFILT_SETTLE_OUT <= '0;
      POSTFILT_RATE_OUT   <= '0;
      RATE_SEL_OUT        <= '0;
      DECIM_OUT           <= '0;
    end else begin
      FILTER_MODE_OUT     <= next_mode;
      POSTFILT_ACTIVE_OUT <= next_pf_act;
      POSTFILT_SEL_OUT    <= direct ? 3'h0 : pf_sel;
      POSTFILT_SETTLE_OUT <= next_pf_act ? next_settle : 16'h0000;
      POSTFILT_RATE_OUT   <= next_pf_act ? next_pf_rate : 16'h0000;
      RATE_SEL_OUT        <= direct ? 5'h00 : cfg[afc_pkg::RATE_HI:0];
      DECIM_OUT           <= direct ? cfg[afc_pkg::DECIM_HI:0] : 15'h0000;
    end
  end

  // ---------------- conversion sequencer ----------------
  afc_pkg::afc_seq_e seq, next_seq;
  logic [3:0] ch, next_ch_q;
  logic       done, next_abort, next_valid;
  logic [7:0] next_restarts;
  logic [3:0] next_res_ch;

  afc_conv_timer #(.CNT_W(CNT_W)) u_timer (
    .clk_in     (MCLK_IN),
    .rst_b_in   (RST_B_IN),
    .restart_in (cfg_wr),
    .run_in     (seq == afc_pkg::SEQ_RUN),
    .tick_in    (MOD_TICK_IN),
    .period_in  (period),
    .done_out   (done)
  );

  always_comb begin
    next_seq      = seq;
    next_ch_q     = ch;
    next_abort    = 1'b0;
    next_valid    = 1'b0;
    next_res_ch   = RESULT_CH_OUT;
    next_restarts = restarts;
    case (seq)
      afc_pkg::SEQ_IDLE: begin
        if (CHAN_EN_IN != '0) begin
          next_seq  = afc_pkg::SEQ_RUN;
          next_ch_q = first_ch(CHAN_EN_IN);
        end
      end
      afc_pkg::SEQ_RUN: begin
        if (CHAN_EN_IN == '0) begin
          next_seq = afc_pkg::SEQ_IDLE;
        end else if (done && !cfg_wr) begin
          next_valid  = 1'b1;
          next_res_ch = ch;
          next_ch_q   = next_ch(CHAN_EN_IN, ch);
        end
      end
      default: next_seq = afc_pkg::SEQ_IDLE;
    endcase
    // a write drops the result in flight and restarts the sequence
    if (cfg_wr) begin
      next_abort    = 1'b1;
      next_ch_q     = first_ch(CHAN_EN_IN);
      next_restarts = restarts + 8'h01;
    end
  end

  always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      seq              <= afc_pkg::SEQ_IDLE;
      ch               <= '0;
      CONV_ABORT_OUT   <= 1'b0;
      RESULT_VALID_OUT <= 1'b0;
      RESULT_CH_OUT    <= '0;
      restarts         <= '0;
    end else begin
      seq              <= next_seq;
      ch               <= next_ch_q;
      CONV_ABORT_OUT   <= next_abort;
      RESULT_VALID_OUT <= next_valid;
      RESULT_CH_OUT    <= next_res_ch;
      restarts         <= next_restarts;
    end
  end

  assign status = {restarts, 1'b0, seq == afc_pkg::SEQ_RUN,
                   FILTER_MODE_OUT, ch};

  // ---------------- checks ----------------
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_cfg_write;
    cfg_wr;
  endsequence

  sequence s_abort_first;
    CONV_ABORT_OUT && ch == first_ch($past(CHAN_EN_IN));
  endsequence

  a_reset_value: assert property (@(posedge MCLK_IN) disable iff (1'b0)
    !RST_B_IN |=> cfg == afc_pkg::CFG_RESET)
    else $error("config register not at reset value");
  a_write_restart: assert property (s_cfg_write |=> s_abort_first)
    else $error("config write did not abort and restart");
  a_no_stale_result: assert property (s_cfg_write |=> !RESULT_VALID_OUT)
    else $error("result delivered after config write");
  a_direct_mode: assert property (direct |=>
    FILTER_MODE_OUT == afc_pkg::MODE_DIRECT && !POSTFILT_ACTIVE_OUT)
    else $error("direct map did not override filter options");
  a_direct_period: assert property (direct |->
    period == CNT_W'(cfg[14:0]) * CNT_W'(32))
    else $error("direct decimation period wrong");
  a_reserved_zero: assert property (!direct |->
    cfg[14:12] == 3'h0 && !cfg[7])
    else $error("reserved bits not zero");
  a_postfilt_gate: assert property (POSTFILT_ACTIVE_OUT |->
    $past(cfg[11]) && $past(cfg[6:5]) == 2'h0 && !$past(cfg[15]))
    else $error("postfilter active without enable and order 00");
  a_settle_code: assert property (next_pf_act && pf_sel == 3'h5 |=>
    POSTFILT_SETTLE_OUT == 16'h01f4 && POSTFILT_RATE_OUT == 16'h07d0)
    else $error("postfilter 101 figures wrong");
  a_settle_27: assert property (next_pf_act && pf_sel == 3'h2 |=>
    POSTFILT_SETTLE_OUT == 16'h016f && POSTFILT_RATE_OUT == 16'h0a8c)
    else $error("postfilter 010 figures wrong");
  a_order_sinc3: assert property (!direct && order == 2'h3 |=>
    FILTER_MODE_OUT == afc_pkg::MODE_SINC3)
    else $error("order 11 did not select sinc3");
  a_rate_select: assert property (!direct |=>
    RATE_SEL_OUT == $past(cfg[4:0]))
    else $error("rate select not passed on");
endmodule

`default_nettype wire

// *** testbench/tb_afc_filter_setup.sv ***
/*
  self-checking bench for the filter setup 0 configuration block.
  assumes afc_pkg is compiled first and the design keeps its AXI4-Lite
  hand-over timing; every wait is bounded by a cycle count.
*/
`default_nettype none

module tb_afc_filter_setup;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk;
  logic        rst_b;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [3:0]  chan_en;
  logic        mod_tick = 1'b0;
  logic [23:0] conv_period;
  logic [1:0]  filter_mode;
  logic        pf_active;
  logic [2:0]  pf_sel;
  logic [15:0] pf_settle;
  logic [15:0] pf_rate;
  logic [4:0]  rate_sel;
  logic [14:0] decim;
  logic        conv_abort;
  logic        result_valid;
  logic [3:0]  result_ch;
  int          bad_count;
  int          checked;

  afc_filter_setup #(.NUM_CH(4), .CNT_W(24)) u_dut (
    .MCLK_IN(mclk), .RST_B_IN(rst_b),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
    .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
    .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
    .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready), .CHAN_EN_IN(chan_en),
    .MOD_TICK_IN(mod_tick), .CONV_PERIOD_IN(conv_period),
    .FILTER_MODE_OUT(filter_mode), .POSTFILT_ACTIVE_OUT(pf_active),
    .POSTFILT_SEL_OUT(pf_sel), .POSTFILT_SETTLE_OUT(pf_settle),
    .POSTFILT_RATE_OUT(pf_rate), .RATE_SEL_OUT(rate_sel),
    .DECIM_OUT(decim), .CONV_ABORT_OUT(conv_abort),
    .RESULT_VALID_OUT(result_valid), .RESULT_CH_OUT(result_ch)
  );

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  // modulator tick: one-cycle pulse every second clock
  always @(posedge mclk) mod_tick <= ~mod_tick;

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic timed_out();
    check(32'h0, 32'h1);
    stop_test();
  endtask

  // outputs are sampled at the falling edge, stimulus moves after rising
  task automatic axi_write(input logic [7:0] a, input logic [15:0] d,
                           output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    logic ta;
    logic tw;
    int   n;
    aw_done = 1'b0;
    w_done  = 1'b0;
    n       = 0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0000, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      if (n++ > 50) timed_out();
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge mclk);
      if (ta) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (tw) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do begin
      if (n++ > 100) timed_out();
      @(negedge mclk);
      tw   = bvalid;
      resp = bresp;
      @(posedge mclk);
    end while (!tw);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    logic t;
    int   n;
    n       = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      if (n++ > 50) timed_out();
      @(negedge mclk);
      t = arready;
      @(posedge mclk);
    end while (!t);
    arvalid <= 1'b0;
    do begin
      if (n++ > 100) timed_out();
      @(negedge mclk);
      t    = rvalid;
      d    = rdata;
      resp = rresp;
      @(posedge mclk);
    end while (!t);
    rready <= 1'b0;
  endtask

  task automatic cfg_write(input logic [15:0] d);
    logic [1:0] r;
    axi_write(afc_pkg::CFG_OFFSET, d, r);
    check(32'(r), 32'(afc_pkg::RESP_OKAY));
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, {16'h0000, exp});
    check(32'(r), 32'(afc_pkg::RESP_OKAY));
  endtask

  task automatic decode_is(input logic [1:0] mode, input logic act,
                           input logic [2:0] sel, input logic [15:0] stl,
                           input logic [15:0] pfr, input logic [4:0] rs,
                           input logic [14:0] dec);
    @(negedge mclk);
    check(32'(filter_mode), 32'(mode));
    check(32'(pf_active), 32'(act));
    check(32'(pf_sel), 32'(sel));
    check(32'(pf_settle), 32'(stl));
    check(32'(pf_rate), 32'(pfr));
    check(32'(rate_sel), 32'(rs));
    check(32'(decim), 32'(dec));
    @(posedge mclk);
  endtask

  task automatic wait_result(output int cyc, output logic [3:0] ch);
    logic t;
    cyc = 0;
    do begin
      if (cyc > 2000) timed_out();
      @(negedge mclk);
      t  = result_valid;
      ch = result_ch;
      @(posedge mclk);
      cyc++;
    end while (!t);
  endtask

  task automatic t_reset();
    reg_is(afc_pkg::CFG_OFFSET, 16'h0500);
    decode_is(2'h0, 1'b0, 3'h5, 16'h0, 16'h0, 5'h0, 15'h0);
    $display("test reset values done");
  endtask

  task automatic t_fields();
    cfg_write(16'h7d7f);
    reg_is(afc_pkg::CFG_OFFSET, 16'h0d7f);
    decode_is(2'h3, 1'b0, 3'h5, 16'h0, 16'h0, 5'h1f, 15'h0);
    cfg_write(16'h0d00);
    decode_is(2'h0, 1'b1, 3'h5, 16'h01f4, 16'h07d0, 5'h0, 15'h0);
    $display("test field decode done");
  endtask

  task automatic t_postfilter();
    // only the four documented variant codes are programmed
    logic [2:0]  code [4] = '{3'h2, 3'h3, 3'h5, 3'h6};
    logic [15:0] stl  [4] = '{16'h016f, 16'h0190, 16'h01f4, 16'h0258};
    logic [15:0] pfr  [4] = '{16'h0a8c, 16'h084d, 16'h07d0, 16'h0683};
    for (int i = 0; i < 4; i++) begin
      cfg_write({4'h0, 1'b1, code[i], 8'h03});
      reg_is(afc_pkg::CFG_OFFSET, {4'h0, 1'b1, code[i], 8'h03});
      decode_is(2'h0, 1'b1, code[i], stl[i], pfr[i], 5'h3, 15'h0);
    end
    cfg_write(16'h0503);
    decode_is(2'h0, 1'b0, 3'h5, 16'h0, 16'h0, 5'h3, 15'h0);
    $display("test postfilter codes done");
  endtask

  task automatic t_direct();
    int         cyc;
    logic [3:0] ch;
    cfg_write(16'hf862);
    reg_is(afc_pkg::CFG_OFFSET, 16'hf862);
    decode_is(2'h2, 1'b0, 3'h0, 16'h0, 16'h0, 5'h0, 15'h7862);
    chan_en     <= 4'b0001;
    conv_period <= 24'h8;
    cfg_write(16'h8002);
    wait_result(cyc, ch);
    wait_result(cyc, ch);
    // 32 x 2 modulator ticks, one tick every two clocks
    check(32'(cyc), 32'h80);
    $display("test direct decimation done");
  endtask

  task automatic t_restart();
    int         cyc;
    int         n;
    logic [3:0] ch;
    logic       seen;
    chan_en <= 4'b1010;
    cfg_write(16'h0500);
    n = 0;
    do begin
      if (n++ > 10) timed_out();
      wait_result(cyc, ch);
    end while (ch !== 4'h1);
    seen = 1'b0;
    // the abort pulse comes while the write response is still pending
    fork
      cfg_write(16'h0500);
      for (n = 0; n < 4; n++) begin
        @(negedge mclk);
        seen = seen | conv_abort;
        @(posedge mclk);
      end
    join
    check(32'(seen), 32'h1);
    wait_result(cyc, ch);
    check(32'(ch), 32'h1);
    $display("test restart on write done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h40, 16'h1234, r);
    check(32'(r), 32'(afc_pkg::RESP_SLVERR));
    axi_read(8'h40, d, r);
    check(32'(r), 32'(afc_pkg::RESP_SLVERR));
    check(d, 32'h0);
    // let rready settle low before the next read raises it again
    @(posedge mclk);
    reg_is(afc_pkg::CFG_OFFSET, 16'h0500);
    $display("test unmapped access done");
  endtask

  initial begin
    bad_count   = 0;
    checked     = 0;
    rst_b       = 1'b0;
    awaddr      = 8'h0;
    awvalid     = 1'b0;
    wdata       = 32'h0;
    wstrb       = 4'h3;
    wvalid      = 1'b0;
    bready      = 1'b0;
    araddr      = 8'h0;
    arvalid     = 1'b0;
    rready      = 1'b0;
    chan_en     = 4'b0001;
    conv_period = 24'h8;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_reset();
    t_fields();
    t_postfilter();
    t_direct();
    t_restart();
    t_unmapped();
    stop_test();
  end
endmodule

`default_nettype wire
